// [rtl/csc_pkg.sv]
/*
  Shared constants for the camera sensor capture block: register map,
  control field positions, reset values, timing modes and embedded
  sync code values.
  Assumes a 32-bit APB register bus and an 8-bit or wider pixel bus.
*/
package csc_pkg;

  // Register byte offsets
  localparam logic [7:0] CSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] CSC_STATUS_OFS = 8'h04;
  localparam logic [7:0] CSC_DATA_OFS = 8'h08;
  localparam logic [7:0] CSC_FRAMES_OFS = 8'h0C;
  localparam logic [7:0] CSC_LINELEN_OFS = 8'h10;

  // Control register fields
  localparam int CSC_CTRL_EN_BIT = 0;
  localparam int CSC_CTRL_MODE_LSB = 1;
  localparam int CSC_CTRL_FRAME_POL_BIT = 3;
  localparam int CSC_CTRL_LINE_POL_BIT = 4;
  localparam int CSC_CTRL_PIX_INV_BIT = 5;
  localparam int CSC_CTRL_W = 6;
  localparam logic [5:0] CSC_CTRL_RST = 6'h00;

  // Status register fields
  localparam int CSC_STAT_OVF_BIT = 0;
  localparam int CSC_STAT_EMPTY_BIT = 1;
  localparam int CSC_STAT_FULL_BIT = 2;
  localparam int CSC_STAT_INFRAME_BIT = 3;
  localparam int CSC_STAT_INLINE_BIT = 4;
  localparam int CSC_STAT_LEVEL_LSB = 8;

  // Counter reset values
  localparam logic [15:0] CSC_COUNT_RST = 16'h0000;

  // Input FIFO depth
  localparam int CSC_FIFO_DEPTH = 32;

  // Timing modes
  typedef enum logic [1:0] {
    CSC_MODE_EMBEDDED = 2'b00,
    CSC_MODE_GATED = 2'b01,
    CSC_MODE_NONGATED = 2'b10,
    CSC_MODE_OFF = 2'b11
  } csc_mode_e;

  // Embedded timing code preamble and flag positions in the XY word
  localparam logic [7:0] CSC_CODE_ONES = 8'hFF;
  localparam logic [7:0] CSC_CODE_ZEROS = 8'h00;
  localparam int CSC_XY_F_BIT = 6;
  localparam int CSC_XY_V_BIT = 5;
  localparam int CSC_XY_H_BIT = 4;

endpackage

// [rtl/csc_stream_if.sv]
/*
  Valid/ready word stream between the capture core and its FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface csc_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [rtl/csc_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module csc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill and drain sides
  csc_stream_if.snk wr,
  csc_stream_if.src rd,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic doWrite;
  logic doRead;

  // Extra pointer bit tells full from empty
  assign level = wrPtr_reg - rdPtr_reg;
  assign wr.ready = (level != (AW+1)'(DEPTH));
  assign rd.valid = (level != '0);
  assign rd.data = mem[rdPtr_reg[AW-1:0]];
  assign doWrite = wr.valid && wr.ready;
  assign doRead = rd.valid && rd.ready;

  // Storage
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg[AW-1:0]] <= wr.data;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule

// [rtl/csc_capture.sv]
/*
  Camera sensor capture front end with APB register access.
  Samples a pixel bus clocked by the sensor in one of three timing
  modes, recovers frame and line syncs, and fills an input FIFO that
  software drains through the data register.
  Assumes the sensor pins are asynchronous to clk and that the pixel
  clock is well below a quarter of clk.
*/
// Local design decisions: the placing of the registers and the APB register port.
// What this block does
// - Three timing modes: embedded, gated, non-gated
// - Embedded mode ignores frame and line inputs
// - Active line runs from SAV to EAV
// - Blanking between EAV and SAV not stored
// - Strip codes, regenerate frame and line syncs
// - Gated mode uses frame, line, pixel clock
// - Frame sync edge starts a new frame
// - Gated mode: pixel edges valid during line
// - Sample data on active pixel clock edge
// - Gated mode: stop after line sync drops
// - Non-gated mode ignores line sync input
// - Non-gated mode: every edge pushes a pixel unless the FIFO is full
// - Programmable frame, line, pixel polarities
// - Invert bit selects falling pixel edge
`timescale 1ns/1ps
module csc_capture #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor pins
  input wire logic sensorPixelClock,
  input wire logic frameSyncIn,
  input wire logic lineSyncIn,
  input wire logic [DATA_W-1:0] pixelData,
  // Recovered syncs and overflow flag for downstream stages
  output logic frameStart,
  output logic lineActive,
  output logic overflow
);
  localparam int LVL_W = $clog2(csc_pkg::CSC_FIFO_DEPTH) + 1;

  // Preamble tracking states for embedded timing codes
  typedef enum logic [1:0] {
    CSC_SYNC_IDLE = 2'b00,
    CSC_SYNC_ONES = 2'b01,
    CSC_SYNC_ZERO1 = 2'b10,
    CSC_SYNC_ZERO2 = 2'b11
  } csc_sync_e;

  // Control and status
  logic [csc_pkg::CSC_CTRL_W-1:0] ctrl_reg;
  logic [15:0] frames_reg, lineLen_reg, pixCount_reg;
  logic overflow_reg, frameStart_reg, lineActive_reg, inFrame_reg;
  csc_pkg::csc_mode_e mode;
  // Synchronisers and edge history
  logic pclkS1_reg, pclkS2_reg, pclkPrev_reg;
  logic frameS1_reg, frameS2_reg, framePrev_reg;
  logic lineS1_reg, lineS2_reg;
  logic [DATA_W-1:0] dataS1_reg, dataS2_reg;
  // Embedded sync decode
  csc_sync_e syncState_reg, syncState_next;
  logic embLine_reg, embVert_reg;
  // Push path and fill level
  logic pushValid_reg;
  logic [DATA_W-1:0] pushData_reg;
  logic [LVL_W-1:0] level;
  // APB
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic apbDone, apbWrite, apbRead, popNow;
  // Decoded events
  logic pixEdge, frameEdge, lineOn, enabled;
  logic [7:0] codeByte;
  logic xyArrives, isEav, isSav, acceptPixel, lineEnds;
  // Stream links around the FIFO
  csc_stream_if #(.WIDTH(DATA_W)) fillSide ();
  csc_stream_if #(.WIDTH(DATA_W)) drainSide ();
  // Control fields
  assign mode = csc_pkg::csc_mode_e'(ctrl_reg[csc_pkg::CSC_CTRL_MODE_LSB +: 2]);
  assign enabled = ctrl_reg[csc_pkg::CSC_CTRL_EN_BIT];
  // Two flops ahead of every sensor pin
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {pclkS1_reg, pclkS2_reg, frameS1_reg, frameS2_reg, lineS1_reg, lineS2_reg} <= 6'h00;
      dataS1_reg <= '0;
      dataS2_reg <= '0;
    end else begin
      pclkS1_reg <= sensorPixelClock;
      pclkS2_reg <= pclkS1_reg;
      frameS1_reg <= frameSyncIn;
      frameS2_reg <= frameS1_reg;
      lineS1_reg <= lineSyncIn;
      lineS2_reg <= lineS1_reg;
      dataS1_reg <= pixelData;
      dataS2_reg <= dataS1_reg;
    end
  end
  // Edge history looks only at the second stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {pclkPrev_reg, framePrev_reg} <= 2'h0;
    end else begin
      pclkPrev_reg <= pclkS2_reg;
      framePrev_reg <= frameS2_reg;
    end
  end
  // Pixel edge with optional inversion; idle-low clock gives no edge
  always_comb begin
    if (ctrl_reg[csc_pkg::CSC_CTRL_PIX_INV_BIT]) begin
      pixEdge = pclkPrev_reg && !pclkS2_reg;
    end else begin
      pixEdge = !pclkPrev_reg && pclkS2_reg;
    end
  end
  // Frame edge and line level after polarity
  always_comb begin
    if (ctrl_reg[csc_pkg::CSC_CTRL_FRAME_POL_BIT]) begin
      frameEdge = framePrev_reg && !frameS2_reg;
    end else begin
      frameEdge = !framePrev_reg && frameS2_reg;
    end
    lineOn = lineS2_reg ^ ctrl_reg[csc_pkg::CSC_CTRL_LINE_POL_BIT];
  end
  // Embedded code fields, taken from the top byte of the bus
  assign codeByte = dataS2_reg[DATA_W-1 -: 8];
  assign xyArrives = (syncState_reg == CSC_SYNC_ZERO2);
  assign isEav = xyArrives && codeByte[csc_pkg::CSC_XY_H_BIT];
  assign isSav = xyArrives && !codeByte[csc_pkg::CSC_XY_H_BIT];
  // Preamble tracker; the code words never reach the FIFO
  always_comb begin
    syncState_next = syncState_reg;
    case (syncState_reg)
      CSC_SYNC_IDLE: begin
        if (codeByte == csc_pkg::CSC_CODE_ONES) begin
          syncState_next = CSC_SYNC_ONES;
        end
      end
      CSC_SYNC_ONES: begin
        if (codeByte == csc_pkg::CSC_CODE_ZEROS) begin
          syncState_next = CSC_SYNC_ZERO1;
        end else if (codeByte != csc_pkg::CSC_CODE_ONES) begin
          syncState_next = CSC_SYNC_IDLE;
        end
      end
      CSC_SYNC_ZERO1: begin
        if (codeByte == csc_pkg::CSC_CODE_ZEROS) begin
          syncState_next = CSC_SYNC_ZERO2;
        end else begin
          syncState_next = CSC_SYNC_IDLE;
        end
      end
      default: begin // XY word closes every code
        syncState_next = CSC_SYNC_IDLE;
      end
    endcase
  end
  // Tracker advances once per pixel edge in embedded mode only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      syncState_reg <= CSC_SYNC_IDLE;
    end else if (!enabled || mode != csc_pkg::CSC_MODE_EMBEDDED) begin
      syncState_reg <= CSC_SYNC_IDLE;
    end else if (pixEdge) begin
      syncState_reg <= syncState_next;
    end
  end
  // Line and vertical blanking recovered from SAV and EAV
  always_ff @(posedge clk) begin
    if (!nrst) begin
      embLine_reg <= 1'b0;
      embVert_reg <= 1'b1;
    end else if (!enabled || mode != csc_pkg::CSC_MODE_EMBEDDED) begin
      embLine_reg <= 1'b0;
      embVert_reg <= 1'b1;
    end else if (pixEdge && xyArrives) begin
      embLine_reg <= isSav && !codeByte[csc_pkg::CSC_XY_V_BIT];
      embVert_reg <= codeByte[csc_pkg::CSC_XY_V_BIT];
    end else if (pixEdge && codeByte == csc_pkg::CSC_CODE_ONES) begin
      embLine_reg <= 1'b0;
    end
  end
  // Which pixel edges carry picture data, per mode
  always_comb begin
    acceptPixel = 1'b0;
    case (mode)
      csc_pkg::CSC_MODE_EMBEDDED: begin
        // Sync pins are not looked at here
        acceptPixel = pixEdge && embLine_reg && !xyArrives
          && codeByte != csc_pkg::CSC_CODE_ONES;
      end
      csc_pkg::CSC_MODE_GATED: begin
        acceptPixel = pixEdge && lineOn;
      end
      csc_pkg::CSC_MODE_NONGATED: begin
        acceptPixel = pixEdge;
      end
      default: begin
        acceptPixel = 1'b0;
      end
    endcase
    acceptPixel = acceptPixel && enabled;
  end
  // Frame start event for the selected mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      frameStart_reg <= 1'b0;
    end else if (!enabled) begin
      frameStart_reg <= 1'b0;
    end else if (mode == csc_pkg::CSC_MODE_EMBEDDED) begin
      frameStart_reg <= pixEdge && isSav && embVert_reg
        && !codeByte[csc_pkg::CSC_XY_V_BIT];
    end else if (mode == csc_pkg::CSC_MODE_GATED || mode == csc_pkg::CSC_MODE_NONGATED) begin
      frameStart_reg <= frameEdge;
    end else begin
      frameStart_reg <= 1'b0;
    end
  end
  // Line active level for downstream stages
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lineActive_reg <= 1'b0;
    end else if (!enabled) begin
      lineActive_reg <= 1'b0;
    end else if (mode == csc_pkg::CSC_MODE_EMBEDDED) begin
      lineActive_reg <= embLine_reg;
    end else if (mode == csc_pkg::CSC_MODE_GATED) begin
      lineActive_reg <= lineOn;
    end else begin
      lineActive_reg <= inFrame_reg;
    end
  end
  // In-frame status and frame counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      inFrame_reg <= 1'b0;
      frames_reg <= csc_pkg::CSC_COUNT_RST;
    end else if (!enabled) begin
      inFrame_reg <= 1'b0;
    end else if (frameStart_reg) begin
      inFrame_reg <= 1'b1;
      frames_reg <= frames_reg + 16'h0001;
    end
  end
  // Pixels per line, latched when the line closes
  assign lineEnds = lineActive_reg && !lineOn && mode == csc_pkg::CSC_MODE_GATED
    || pixEdge && isEav && mode == csc_pkg::CSC_MODE_EMBEDDED;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pixCount_reg <= csc_pkg::CSC_COUNT_RST;
      lineLen_reg <= csc_pkg::CSC_COUNT_RST;
    end else if (lineEnds) begin
      lineLen_reg <= pixCount_reg;
      pixCount_reg <= csc_pkg::CSC_COUNT_RST;
    end else if (acceptPixel) begin
      pixCount_reg <= pixCount_reg + 16'h0001;
    end
  end
  // One-cycle push toward the FIFO; it cannot stall a sensor
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pushValid_reg <= 1'b0;
      pushData_reg <= '0;
    end else begin
      pushValid_reg <= acceptPixel && fillSide.ready;
      if (acceptPixel) begin
        pushData_reg <= dataS2_reg;
      end
    end
  end
  assign fillSide.valid = pushValid_reg;
  assign fillSide.data = pushData_reg;
  // Input FIFO
  csc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(csc_pkg::CSC_FIFO_DEPTH)
  ) inputFifo (
    .clk(clk),
    .nrst(nrst),
    .wr(fillSide),
    .rd(drainSide),
    .level(level)
  );
  // APB handshake: one wait state, answer registered
  assign apbDone = psel && penable && pready_reg;
  assign apbWrite = apbDone && pwrite;
  assign apbRead = apbDone && !pwrite;
  assign popNow = apbRead && paddr == csc_pkg::CSC_DATA_OFS;
  assign drainSide.ready = popNow;
  // Sticky overflow; a new overflow wins over a clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      overflow_reg <= 1'b0;
    end else if (acceptPixel && !fillSide.ready) begin
      overflow_reg <= 1'b1;
    end else if (apbWrite && paddr == csc_pkg::CSC_STATUS_OFS
      && pwdata[csc_pkg::CSC_STAT_OVF_BIT]) begin
      overflow_reg <= 1'b0;
    end
  end
  // Control register write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= csc_pkg::CSC_CTRL_RST;
    end else if (apbWrite && paddr == csc_pkg::CSC_CTRL_OFS) begin
      ctrl_reg <= pwdata[csc_pkg::CSC_CTRL_W-1:0];
    end
  end
  // Ready, read data and error are formed one edge before completion
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      if (psel && penable && !pready_reg) begin
        if (paddr == csc_pkg::CSC_CTRL_OFS) begin
          prdata_reg[csc_pkg::CSC_CTRL_W-1:0] <= ctrl_reg;
        end else if (paddr == csc_pkg::CSC_STATUS_OFS) begin
          prdata_reg[csc_pkg::CSC_STAT_OVF_BIT] <= overflow_reg;
          prdata_reg[csc_pkg::CSC_STAT_EMPTY_BIT] <= !drainSide.valid;
          prdata_reg[csc_pkg::CSC_STAT_FULL_BIT] <= !fillSide.ready;
          prdata_reg[csc_pkg::CSC_STAT_INFRAME_BIT] <= inFrame_reg;
          prdata_reg[csc_pkg::CSC_STAT_INLINE_BIT] <= lineActive_reg;
          prdata_reg[csc_pkg::CSC_STAT_LEVEL_LSB +: LVL_W] <= level;
        end else if (paddr == csc_pkg::CSC_DATA_OFS) begin
          // Empty FIFO reads as zero and pops nothing
          if (drainSide.valid) begin
            prdata_reg[DATA_W-1:0] <= drainSide.data;
          end
        end else if (paddr == csc_pkg::CSC_FRAMES_OFS) begin
          prdata_reg[15:0] <= frames_reg;
        end else if (paddr == csc_pkg::CSC_LINELEN_OFS) begin
          prdata_reg[15:0] <= lineLen_reg;
        end else begin
          pslverr_reg <= 1'b1;
        end
      end
    end
  end
  // Outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign frameStart = frameStart_reg;
  assign lineActive = lineActive_reg;
  assign overflow = overflow_reg;
endmodule

// [verif/csc_capture_checker.sv]
/*
  Port-level assertions for the camera sensor capture block.
  Assumes it is bound onto csc_capture and sees only its ports.
*/
`timescale 1ns/1ps
module csc_capture_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Syncs and recovered outputs
  input wire logic frameSyncIn,
  input wire logic lineSyncIn,
  input wire logic frameStart,
  input wire logic lineActive,
  input wire logic overflow
);
  logic [5:0] ctrlShadow;
  logic apbDone;
  logic gatedPlain;
  logic ovfClear;
  // Finished transfers; gated mode with straight polarities
  assign apbDone = psel && penable && pready;
  assign ovfClear = apbDone && pwrite && paddr == csc_pkg::CSC_STATUS_OFS && pwdata[0];
  assign gatedPlain = ctrlShadow == 6'h03;
  // Shadow of control, since mode checks cannot see inside
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrlShadow <= csc_pkg::CSC_CTRL_RST;
    end else if (apbDone && pwrite && paddr == csc_pkg::CSC_CTRL_OFS) begin
      ctrlShadow <= pwdata[5:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Access phase before the answer
  sequence s_access;
    psel && penable && !pready;
  endsequence
  // Line sync idle for a while in plain gated mode
  sequence s_line_gone;
    (gatedPlain && !lineSyncIn) [*6];
  endsequence
  a_apb_wait: assert property (s_access |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_in_xfer: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_err_unmapped: assert property (pready && paddr > 8'h10 |-> pslverr) else $error("no error");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_frame_pulse: assert property (frameStart |=> !frameStart) else $error("frame pulse long");
  a_frame_edge: assert property (gatedPlain && $rose(frameSyncIn) |-> ##[2:8] frameStart)
    else $error("frame edge missed");
  a_line_stop: assert property (s_line_gone |-> !lineActive) else $error("line still active");
  a_ovf_sticky: assert property (overflow && !ovfClear |=> overflow) else $error("overflow lost");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !frameStart && !lineActive && !overflow && !pready)
    else $error("outputs active in reset");
endmodule
bind csc_capture csc_capture_checker uChk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .frameSyncIn, .lineSyncIn, .frameStart, .lineActive, .overflow);

// [verif/csc_sensor_model.sv]
/*
  Behavioural image sensor driving the pixel bus, 8-bit data.
  Assumes callers enter its tasks right after a rising clk edge.
*/
`timescale 1ns/1ps
module csc_sensor_model (
  // Pacing clock
  input wire logic clk,
  // Sensor pins
  output logic sensorPixelClock,
  output logic frameSyncIn,
  output logic lineSyncIn,
  output logic [7:0] pixelData
);
  logic pixInv = 1'b0;
  logic frameFall = 1'b0;
  logic lineLow = 1'b0;
  logic pcRaw = 1'b0;
  logic fsRaw = 1'b0;
  logic lsRaw = 1'b0;
  // Raw levels are straight; polarity is applied only at the pins
  assign sensorPixelClock = pcRaw ^ pixInv;
  assign frameSyncIn = fsRaw ^ frameFall;
  assign lineSyncIn = lsRaw ^ lineLow;
  initial pixelData = 8'h00;
  // One 32 ns pixel clock period, data set well before the edge
  task automatic pix(input logic [7:0] d);
    pixelData <= d;
    repeat (2) @(posedge clk);
    pcRaw <= 1'b1;
    repeat (4) @(posedge clk);
    pcRaw <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Frame sync pulse
  task automatic frame();
    fsRaw <= 1'b1;
    repeat (6) @(posedge clk);
    fsRaw <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Line of n pixels; gate chooses whether line sync frames it
  task automatic line(input int n, input logic [7:0] base, input logic gate);
    lsRaw <= gate;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      pix(8'(base + i));
    end
    lsRaw <= 1'b0;
    pixelData <= ~pixelData;
    repeat (4) @(posedge clk);
  endtask
  // Embedded timing code, carried in the data only
  task automatic code(input logic [7:0] xy);
    pix(8'hFF);
    pix(8'h00);
    pix(8'h00);
    pix(xy);
  endtask
endmodule

// [verif/csc_tb.sv]
/*
  Self-checking bench for the capture block over APB and sensor pins.
  Assumes the package, FIFO, interface and sensor model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] ACTRL = csc_pkg::CSC_CTRL_OFS;
  localparam logic [7:0] ASTAT = csc_pkg::CSC_STATUS_OFS;
  localparam logic [7:0] ADATA = csc_pkg::CSC_DATA_OFS;
  logic clk = 1'b0;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, sensorPixelClock, frameSyncIn, lineSyncIn, frameStart, lineActive, overflow;
  logic [7:0] pixelData;
  int badCount = 0;
  int cmpCount = 0;
  int fsCount = 0;
  always #2 clk = ~clk;
  csc_capture dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sensorPixelClock, .frameSyncIn, .lineSyncIn, .pixelData, .frameStart, .lineActive, .overflow);
  csc_sensor_model sensor (.clk, .sensorPixelClock, .frameSyncIn, .lineSyncIn, .pixelData);
  // Frame pulses counted so each test judges its own share
  always @(posedge clk) begin
    if (frameStart === 1'b1) fsCount <= fsCount + 1;
  end
  task automatic endSim();
    $display("Compares %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; answer taken at the rising edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        badCount++;
        $display("[FAIL] pready expected 1 seen 0");
        endSim();
      end
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(what, exp, q & m);
  endtask
  task automatic drain(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      rdChk("pixel word", ADATA, 32'hFFFFFFFF, {24'h000000, 8'(base + i)});
    end
  endtask
  task automatic tRegs();
    logic [31:0] q;
    logic e;
    rdChk("ctrl reset", ACTRL, 32'hFFFFFFFF, 32'h00000000);
    rdChk("status reset", ASTAT, 32'h00003F1F, 32'h00000002);
    rdChk("frames reset", csc_pkg::CSC_FRAMES_OFS, 32'hFFFFFFFF, 32'h00000000);
    rdChk("empty data", ADATA, 32'hFFFFFFFF, 32'h00000000);
    apb(1'b0, 8'h14, 32'h00000000, q, e);
    chk("unmapped error", 32'h00000001, {31'h00000000, e});
    chk("unmapped data", 32'h00000000, q);
    wr(ACTRL, 32'h0000003B);
    rdChk("ctrl write", ACTRL, 32'hFFFFFFFF, 32'h0000003B);
    wr(ACTRL, 32'h00000000);
    $display("tRegs done");
  endtask
  task automatic tGated();
    int f0;
    wr(ACTRL, 32'h00000003);
    f0 = fsCount;
    sensor.frame();
    chk("gated frames", 32'(f0 + 1), 32'(fsCount));
    sensor.line(3, 8'h11, 1'b1);
    sensor.line(2, 8'h77, 1'b0);
    repeat (10) @(posedge clk);
    rdChk("gated level", ASTAT, 32'h00003F00, 32'h00000300);
    drain(3, 8'h11);
    rdChk("line length", csc_pkg::CSC_LINELEN_OFS, 32'h0000FFFF, 32'h00000003);
    rdChk("frame count", csc_pkg::CSC_FRAMES_OFS, 32'h0000FFFF, 32'h00000001);
    wr(ACTRL, 32'h00000000);
    $display("tGated done");
  endtask
  task automatic tNongated();
    wr(ACTRL, 32'h00000007);
    sensor.line(2, 8'h60, 1'b1);
    rdChk("off level", ASTAT, 32'h00003F00, 32'h00000000);
    wr(ACTRL, 32'h00000005);
    sensor.frame();
    sensor.line(4, 8'h40, 1'b0);
    sensor.line(2, 8'h50, 1'b1);
    repeat (10) @(posedge clk);
    rdChk("free level", ASTAT, 32'h00003F00, 32'h00000600);
    drain(4, 8'h40);
    drain(2, 8'h50);
    wr(ACTRL, 32'h00000000);
    $display("tNongated done");
  endtask
  task automatic tPol();
    int f0;
    sensor.pixInv <= 1'b1;
    sensor.frameFall <= 1'b1;
    sensor.lineLow <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ACTRL, 32'h0000003B);
    f0 = fsCount;
    sensor.frame();
    chk("falling frames", 32'(f0 + 1), 32'(fsCount));
    sensor.line(2, 8'hA0, 1'b1);
    repeat (10) @(posedge clk);
    rdChk("inverted level", ASTAT, 32'h00003F00, 32'h00000200);
    drain(2, 8'hA0);
    wr(ACTRL, 32'h00000000);
    sensor.pixInv <= 1'b0;
    sensor.frameFall <= 1'b0;
    sensor.lineLow <= 1'b0;
    repeat (4) @(posedge clk);
    $display("tPol done");
  endtask
  task automatic tEmbedded();
    int f0;
    wr(ACTRL, 32'h00000001);
    f0 = fsCount;
    sensor.frame();
    sensor.line(1, 8'h33, 1'b1);
    sensor.code(8'hB0);
    sensor.pix(8'h10);
    sensor.pix(8'h10);
    sensor.code(8'h80);
    sensor.pix(8'h21);
    @(negedge clk);
    chk("line active", 32'h00000001, {31'h00000000, lineActive});
    @(posedge clk);
    sensor.pix(8'h22);
    sensor.code(8'h90);
    sensor.pix(8'h10);
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("line idle", 32'h00000000, {31'h00000000, lineActive});
    @(posedge clk);
    chk("embedded frames", 32'(f0 + 1), 32'(fsCount));
    rdChk("embedded level", ASTAT, 32'h00003F00, 32'h00000200);
    drain(2, 8'h21);
    wr(ACTRL, 32'h00000000);
    $display("tEmbedded done");
  endtask
  task automatic tOverflow();
    wr(ACTRL, 32'h00000005);
    sensor.frame();
    sensor.line(33, 8'h00, 1'b0);
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("overflow pin", 32'h00000001, {31'h00000000, overflow});
    @(posedge clk);
    rdChk("full status", ASTAT, 32'h00003F07, 32'h00002005);
    wr(ASTAT, 32'h00000001);
    rdChk("overflow clear", ASTAT, 32'h00000001, 32'h00000000);
    drain(32, 8'h00);
    rdChk("empty again", ASTAT, 32'h00003F07, 32'h00000002);
    wr(ACTRL, 32'h00000000);
    $display("tOverflow done");
  endtask
  // Reset, then the scenarios in turn
  initial begin
    nrst <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h00000000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    tRegs();
    tGated();
    tNongated();
    tPol();
    tEmbedded();
    tOverflow();
    endSim();
  end
endmodule
